// ==== bench/fieldbus_master_model.sv ====
// Fieldbus master model driving the remote input bits
`timescale 1ns/1ns
module fieldbus_master_model (
  input wire logic clk_i,
  output logic servo_o,
  output logic fwd_o,
  output logic rev_o,
  output logic [7:0] sel_o
);
  initial begin
    servo_o = 1'b0;
    fwd_o = 1'b0;
    rev_o = 1'b0;
    sel_o = 8'h00;
  end
  task automatic set_servo(input logic on);
    @(posedge clk_i);
    #1 servo_o = on;
  endtask
  // Selection settles through the sync stages before the start edge
  task automatic start(input logic dir, input logic [7:0] tbl);
    @(posedge clk_i);
    #1 sel_o = tbl;
    repeat (3) @(posedge clk_i);
    #1 fwd_o = !dir;
    rev_o = dir;
    repeat (6) @(posedge clk_i);
    #1 fwd_o = 1'b0;
    rev_o = 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
  endtask
endmodule // fieldbus_master_model

// ==== bench/point_table_ctrl_props.sv ====
// Concurrent checks on the point table control ports
`timescale 1ns/1ns
module point_table_ctrl_props (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic servo_on_request_i,
  input wire logic forward_start_i,
  input wire logic reverse_start_i,
  input wire logic link_up_i,
  input wire logic init_done_i,
  input wire logic alarm_i,
  input wire logic warning_i,
  input wire logic watchdog_fail_i,
  input wire logic start_o,
  input wire logic start_reject_o,
  input wire logic [7:0] table_no_o,
  input wire logic drive_enable_o,
  input wire logic not_ready_o,
  input wire logic [7:0] seg0_o,
  input wire logic [7:0] seg1_o,
  input wire logic [7:0] seg2_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_start_one_cycle: assert property (start_o |=> !start_o) else $error("start pulse too long");
  // Sync depth is two or three edges, so either past sample may carry the cause
  a_start_has_cause: assert property (start_o |-> ($past(forward_start_i, 2) || $past(reverse_start_i, 2) ||
    $past(forward_start_i, 3) || $past(reverse_start_i, 3))) else $error("start without request");
  a_start_valid_table: assert property (start_o |-> !start_reject_o && table_no_o != 8'h00)
    else $error("start on table zero");
  a_reject_one_cycle: assert property (start_reject_o |=> !start_reject_o) else $error("reject too long");
  a_table_hold_idle: assert property (!start_o |-> $stable(table_no_o)) else $error("table moved");
  a_servo_off_coast: assert property (!servo_on_request_i [*4] |=> !drive_enable_o)
    else $error("drive on without servo");
  a_init_not_ready: assert property (!init_done_i [*3] |=> not_ready_o) else $error("ready while init");
  a_alarm_not_ready: assert property (alarm_i [*3] |=> not_ready_o) else $error("ready in alarm");
  a_wdog_all_eight: assert property (watchdog_fail_i |-> ##5 (seg0_o[6:0] == 7'h7f &&
    seg1_o[6:0] == 7'h7f && seg2_o[6:0] == 7'h7f)) else $error("no 888");
  a_link_wait_b: assert property ((!link_up_i && !alarm_i && !warning_i && !watchdog_fail_i) [*6]
    |-> seg0_o[6:0] == 7'h7c) else $error("no link wait letter");
  c_start: cover property (start_o);
  c_reject: cover property (start_reject_o);
  c_flicker: cover property ($rose(seg1_o[7]));
endmodule // point_table_ctrl_props

bind point_table_ctrl point_table_ctrl_props point_table_ctrl_props_inst (.clk_i, .rst_n_i, .servo_on_request_i,
  .forward_start_i, .reverse_start_i, .link_up_i, .init_done_i, .alarm_i, .warning_i, .watchdog_fail_i,
  .start_o, .start_reject_o, .table_no_o, .drive_enable_o, .not_ready_o, .seg0_o, .seg1_o, .seg2_o);

// ==== bench/point_table_select_status_display_tb.sv ====
// Self-checking bench for point table selection, start and status display
`timescale 1ns/1ns
module point_table_select_status_display_tb;
  import pts_pkg::*;
  typedef struct packed {logic rej; logic dir; logic [7:0] tbl; logic signed [39:0] pos; logic [15:0] spd;} exp_t;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic servo, fwd, rev, two_st = 1'b0, reg_en = 1'b0, link = 1'b0, init = 1'b0, alarm = 1'b0, warn = 1'b0;
  logic fstop = 1'b0, wdog = 1'b0, test = 1'b0, incr = 1'b0, wr = 1'b0;
  logic [7:0] sel, reg_no = 8'h00, code = 8'h16, wr_idx = 8'h00, tbl_no;
  logic [6:0] station = 7'h01;
  logic [1:0] mult = 2'h0;
  logic [2:0] wr_item = 3'h0;
  logic [31:0] wr_data = 32'h0;
  logic start, reverse, reject, drive, nrdy;
  logic signed [39:0] target;
  logic [15:0] speed, accel, decel, dwell;
  logic [3:0] aux;
  logic [7:0] seg0, seg1, seg2;
  logic [15:0] spd [256];
  logic signed [31:0] pos1;
  exp_t exp_q [$];
  exp_t e;
  int n_checks = 0;
  int n_mismatch = 0;
  always #5 clk_i = ~clk_i;
  fieldbus_master_model fieldbus_master_model_inst (.clk_i, .servo_o(servo), .fwd_o(fwd), .rev_o(rev), .sel_o(sel));
  point_table_ctrl #(.READY_CYCLES(20), .FLICKER_CYCLES(4)) point_table_ctrl_inst (.clk_i, .rst_n_i,
    .servo_on_request_i(servo), .forward_start_i(fwd), .reverse_start_i(rev), .table_select_bit0_i(sel[0]),
    .table_select_bit1_i(sel[1]), .table_select_bit2_i(sel[2]), .table_select_bit3_i(sel[3]),
    .table_select_bit4_i(sel[4]), .table_select_bit5_i(sel[5]), .table_select_bit6_i(sel[6]),
    .table_select_bit7_i(sel[7]), .two_stations_i(two_st), .reg_select_en_i(reg_en), .reg_table_no_i(reg_no),
    .link_up_i(link), .init_done_i(init), .alarm_i(alarm), .warning_i(warn), .forced_stop_warning_i(fstop),
    .alarm_code_i(code), .watchdog_fail_i(wdog), .test_mode_i(test), .station_no_i(station),
    .incremental_mode_i(incr), .feed_length_multiplier_i(mult), .tbl_wr_i(wr), .tbl_wr_index_i(wr_idx),
    .tbl_wr_item_i(wr_item), .tbl_wr_data_i(wr_data), .start_o(start), .reverse_o(reverse),
    .start_reject_o(reject), .table_no_o(tbl_no), .target_pos_o(target), .speed_o(speed), .accel_o(accel),
    .decel_o(decel), .dwell_o(dwell), .aux_o(aux), .drive_enable_o(drive), .not_ready_o(nrdy),
    .seg0_o(seg0), .seg1_o(seg1), .seg2_o(seg2));
  task automatic chk(input logic [39:0] got, input logic [39:0] want);
    n_checks++;
    if (got !== want) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic disp(input logic [6:0] a, input logic [6:0] b, input logic [6:0] c);
    @(negedge clk_i);
    chk({seg0[6:0], seg1[6:0], seg2[6:0]}, {a, b, c});
    @(posedge clk_i);
    #1;
  endtask
  task automatic wr_entry(input logic [7:0] idx, input logic signed [31:0] p);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_i);
      #1 wr = 1'b1;
      wr_idx = idx;
      wr_item = 3'(i);
      wr_data = (i == 0) ? p : {16'h0, spd[idx] ^ 16'(i - 1)};
    end
    @(posedge clk_i);
    #1 wr = 1'b0;
  endtask
  // Expected target is the table value times ten to the multiplier
  task automatic go(input logic d, input logic [7:0] s, input logic [7:0] t, input logic r,
      input logic signed [31:0] p);
    logic signed [39:0] x;
    x = p;
    repeat (mult) x = x * 10;
    exp_q.push_back('{r, d, t, x, spd[t]});
    fieldbus_master_model_inst.start(d, s);
  endtask
  task automatic flick(output logic seen);
    logic first;
    @(negedge clk_i);
    first = seg1[7];
    seen = 1'b0;
    repeat (12) @(negedge clk_i) if (seg1[7] !== first) seen = 1'b1;
    @(posedge clk_i);
    #1;
  endtask
  logic fl;
  always @(negedge clk_i) begin
    if (start === 1'b1 || reject === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(40'h1, 40'h0);
      end else begin
        e = exp_q.pop_front();
        chk(reject, e.rej);
        if (!e.rej) begin
          chk({reverse, tbl_no, speed}, {e.dir, e.tbl, e.spd});
          chk(target, e.pos);
          chk({accel, decel}, {e.spd ^ 16'h0001, e.spd ^ 16'h0002});
          chk({dwell, aux}, {e.spd ^ 16'h0003, 4'(e.spd ^ 16'h0004)});
        end
      end
    end
  end
  initial begin
    #100000;
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'hfafc));
    foreach (spd[i]) spd[i] = 16'($urandom);
    idle(16);
    rst_n_i = 1'b1;
    idle(8);
    disp(7'h7c, 7'h3f, 7'h06);
    test = 1'b1;
    idle(6);
    disp(7'h7c, 7'h3f, 7'h3f);
    test = 1'b0;
    station = 7'h40;
    idle(6);
    disp(7'h7c, 7'h7d, 7'h66);
    station = 7'h01;
    link = 1'b1;
    idle(6);
    disp(7'h39, 7'h3f, 7'h06);
    pos1 = $urandom_range(999999);
    wr_entry(8'd1, pos1);
    wr_entry(8'd255, 32'sd999999);
    wr_entry(8'd31, -32'sd999999);
    wr_entry(8'd2, 32'sd10000000);
    wr_entry(8'd3, -32'sd1);
    init = 1'b1;
    fieldbus_master_model_inst.set_servo(1'b1);
    idle(8);
    disp(7'h5e, 7'h3f, 7'h06);
    idle(10);
    disp(7'h5e, 7'h3f, 7'h06);
    idle(15);
    disp(7'h00, 7'h00, 7'h00);
    mult = 2'h2;
    go(1'b0, 8'd1, 8'd1, 1'b0, pos1);
    mult = 2'h0;
    two_st = 1'b1;
    incr = 1'b1;
    go(1'b1, 8'd255, 8'd255, 1'b0, 32'sd999999);
    go(1'b0, 8'd3, 8'd3, 1'b1, 0);
    incr = 1'b0;
    reg_en = 1'b1;
    reg_no = 8'd31;
    mult = 2'h3;
    go(1'b0, 8'd2, 8'd31, 1'b0, -32'sd999999);
    reg_en = 1'b0;
    go(1'b0, 8'd2, 8'd2, 1'b1, 0);
    two_st = 1'b0;
    go(1'b1, 8'he1, 8'd1, 1'b0, pos1);
    go(1'b0, 8'h00, 8'h00, 1'b1, 0);
    chk(drive, 1'b1);
    chk(nrdy, 1'b0);
    fieldbus_master_model_inst.set_servo(1'b0);
    idle(6);
    chk(drive, 1'b0);
    go(1'b0, 8'd1, 8'd1, 1'b1, 0);
    fieldbus_master_model_inst.set_servo(1'b1);
    alarm = 1'b1;
    idle(8);
    disp(7'h77, 7'h06, 7'h7d);
    chk(nrdy, 1'b1);
    alarm = 1'b0;
    warn = 1'b1;
    idle(6);
    flick(fl);
    chk(fl, 1'b1);
    fstop = 1'b1;
    idle(6);
    flick(fl);
    chk(fl, 1'b0);
    wdog = 1'b1;
    idle(8);
    disp(7'h7f, 7'h7f, 7'h7f);
    chk(40'(exp_q.size()), 40'h0);
    report_and_stop();
  end
endmodule // point_table_select_status_display_tb

// ==== rtl/disp_if.sv ====
// Character and decimal point carrier between control and segment driver
`timescale 1ns/1ns
interface disp_if;
  import pts_pkg::*;
  char_t ch0;
  char_t ch1;
  char_t ch2;
  logic [2:0] dp;
  modport src (output ch0, ch1, ch2, dp);
  modport snk (input ch0, ch1, ch2, dp);
endinterface

// ==== rtl/point_table_ctrl.sv ====
// Point table selection, start control and status display sequencing
`timescale 1ns/1ns
`include "pts_cfg.svh"
module point_table_ctrl
  import pts_pkg::*;
#(
  parameter int unsigned READY_CYCLES = `PTS_READY_TIME_MS * (`PTS_CLK_HZ / 1000),
  parameter int unsigned FLICKER_CYCLES = `PTS_FLICKER_TIME_MS * (`PTS_CLK_HZ / 1000)
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Remote inputs from the fieldbus master
  input wire logic servo_on_request_i,
  input wire logic forward_start_i,
  input wire logic reverse_start_i,
  input wire logic table_select_bit0_i,
  input wire logic table_select_bit1_i,
  input wire logic table_select_bit2_i,
  input wire logic table_select_bit3_i,
  input wire logic table_select_bit4_i,
  input wire logic table_select_bit5_i,
  input wire logic table_select_bit6_i,
  input wire logic table_select_bit7_i,
  // Configuration and status from the rest of the amplifier
  input wire logic two_stations_i,
  input wire logic reg_select_en_i,
  input wire logic [7:0] reg_table_no_i,
  input wire logic link_up_i,
  input wire logic init_done_i,
  input wire logic alarm_i,
  input wire logic warning_i,
  input wire logic forced_stop_warning_i,
  input wire logic [7:0] alarm_code_i,
  input wire logic watchdog_fail_i,
  input wire logic test_mode_i,
  input wire logic [6:0] station_no_i,
  input wire logic incremental_mode_i,
  input wire logic [1:0] feed_length_multiplier_i,
  // Table write port
  input wire logic tbl_wr_i,
  input wire logic [7:0] tbl_wr_index_i,
  input wire logic [2:0] tbl_wr_item_i,
  input wire logic [31:0] tbl_wr_data_i,
  // Motion command
  output logic start_o,
  output logic reverse_o,
  output logic start_reject_o,
  output logic [7:0] table_no_o,
  output logic signed [39:0] target_pos_o,
  output logic [15:0] speed_o,
  output logic [15:0] accel_o,
  output logic [15:0] decel_o,
  output logic [15:0] dwell_o,
  output logic [3:0] aux_o,
  output logic drive_enable_o,
  output logic not_ready_o,
  // Display segments, digit 0 leftmost
  output logic [7:0] seg0_o,
  output logic [7:0] seg1_o,
  output logic [7:0] seg2_o
);

  localparam int DEPTH = `PTS_TABLE_DEPTH;

  disp_if disp ();

  // Remote bits come from the fieldbus domain; all pass two flops
  logic [10:0] remote_raw;
  logic [10:0] remote_meta_reg;
  logic [10:0] remote_sync_reg;
  logic servo_on;
  logic fwd;
  logic rev;
  logic [7:0] sel_bits;

  assign remote_raw = {table_select_bit7_i, table_select_bit6_i, table_select_bit5_i,
                       table_select_bit4_i, table_select_bit3_i, table_select_bit2_i,
                       table_select_bit1_i, table_select_bit0_i,
                       reverse_start_i, forward_start_i, servo_on_request_i};

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      remote_meta_reg <= 11'h000;
      remote_sync_reg <= 11'h000;
    end else begin
      remote_meta_reg <= remote_raw;
      remote_sync_reg <= remote_meta_reg;
    end
  end

  assign servo_on = remote_sync_reg[0];
  assign fwd = remote_sync_reg[1];
  assign rev = remote_sync_reg[2];
  assign sel_bits = remote_sync_reg[10:3];

  // Edge detection on the synchronised levels
  logic servo_on_d_reg;
  logic fwd_d_reg;
  logic rev_d_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      servo_on_d_reg <= 1'b0;
      fwd_d_reg <= 1'b0;
      rev_d_reg <= 1'b0;
    end else begin
      servo_on_d_reg <= servo_on;
      fwd_d_reg <= fwd;
      rev_d_reg <= rev;
    end
  end

  logic servo_rise;
  logic fwd_rise;
  logic rev_rise;
  // Flops start low, so a level already high at reset release reads as an edge
  assign servo_rise = servo_on & ~servo_on_d_reg;
  assign fwd_rise = fwd & ~fwd_d_reg;
  assign rev_rise = rev & ~rev_d_reg;

  // Point table storage, entry 0 unused
  logic signed [31:0] pos_mem [1:DEPTH];
  logic [15:0] speed_mem [1:DEPTH];
  logic [15:0] accel_mem [1:DEPTH];
  logic [15:0] decel_mem [1:DEPTH];
  logic [15:0] dwell_mem [1:DEPTH];
  logic [3:0] aux_mem [1:DEPTH];

  // Writes to index zero are dropped; there is no such entry
  always_ff @(posedge clk_i) begin
    if (tbl_wr_i && tbl_wr_index_i != 8'h00) begin
      case (tbl_wr_item_i)
        `PTS_ITEM_POS: pos_mem[tbl_wr_index_i] <= tbl_wr_data_i;
        `PTS_ITEM_SPEED: speed_mem[tbl_wr_index_i] <= tbl_wr_data_i[15:0];
        `PTS_ITEM_ACCEL: accel_mem[tbl_wr_index_i] <= tbl_wr_data_i[15:0];
        `PTS_ITEM_DECEL: decel_mem[tbl_wr_index_i] <= tbl_wr_data_i[15:0];
        `PTS_ITEM_DWELL: dwell_mem[tbl_wr_index_i] <= tbl_wr_data_i[15:0];
        `PTS_ITEM_AUX: aux_mem[tbl_wr_index_i] <= tbl_wr_data_i[3:0];
        default: ;
      endcase
    end
  end

  // Table number selection
  logic [7:0] sel_code;
  always_comb begin
    if (!two_stations_i) begin
      sel_code = {3'h0, sel_bits[4:0]};
    end else if (reg_select_en_i) begin
      sel_code = reg_table_no_i;
    end else begin
      sel_code = sel_bits;
    end
  end

  // Range check and scaling of the selected position
  logic signed [31:0] sel_pos;
  logic pos_ok;
  logic signed [39:0] pow10;
  logic signed [39:0] scaled_pos;

  assign sel_pos = (sel_code != 8'h00) ? pos_mem[sel_code] : 32'sh0;

  always_comb begin
    if (incremental_mode_i) begin
      pos_ok = (sel_pos >= `PTS_INC_MIN) && (sel_pos <= `PTS_INC_MAX);
    end else begin
      pos_ok = (sel_pos >= `PTS_ABS_MIN) && (sel_pos <= `PTS_ABS_MAX);
    end
  end

  always_comb begin
    case (feed_length_multiplier_i)
      2'h0: pow10 = 40'sd1;
      2'h1: pow10 = 40'sd10;
      2'h2: pow10 = 40'sd100;
      default: pow10 = 40'sd1000;
    endcase
  end

  // Product fits 40 bits: 9999999 times 1000 stays below two to the 34
  logic signed [79:0] product;
  assign product = 80'(sel_pos) * 80'(pow10);
  assign scaled_pos = product[39:0];

  logic can_run;
  logic start_req;
  assign can_run = servo_on & init_done_i & ~alarm_i & ~watchdog_fail_i & link_up_i;
  // Both edges together count as one forward start
  assign start_req = fwd_rise | rev_rise;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start_o <= 1'b0;
      start_reject_o <= 1'b0;
      reverse_o <= 1'b0;
      table_no_o <= 8'h00;
      target_pos_o <= 40'sh0;
      speed_o <= 16'h0000;
      accel_o <= 16'h0000;
      decel_o <= 16'h0000;
      dwell_o <= 16'h0000;
      aux_o <= 4'h0;
    end else begin
      start_o <= 1'b0;
      start_reject_o <= 1'b0;
      if (start_req) begin
        if (can_run && sel_code != 8'h00 && pos_ok) begin
          start_o <= 1'b1;
          reverse_o <= rev_rise & ~fwd_rise;
          table_no_o <= sel_code;
          target_pos_o <= scaled_pos;
          speed_o <= speed_mem[sel_code];
          accel_o <= accel_mem[sel_code];
          decel_o <= decel_mem[sel_code];
          dwell_o <= dwell_mem[sel_code];
          aux_o <= aux_mem[sel_code];
        end else begin
          start_reject_o <= 1'b1;
        end
      end
    end
  end

  // Drive is cut the cycle after servo-on drops
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drive_enable_o <= 1'b0;
      not_ready_o <= 1'b1;
    end else begin
      drive_enable_o <= can_run;
      not_ready_o <= ~init_done_i | alarm_i;
    end
  end

  // Display sequencing
  disp_state_t state_reg;
  disp_state_t state_next;
  logic [27:0] ready_cnt_reg;
  logic ready_done;

  assign ready_done = (ready_cnt_reg == 28'h0000000);

  always_comb begin
    state_next = state_reg;
    if (watchdog_fail_i || state_reg == ST_WDOG) begin
      state_next = ST_WDOG;
    end else if (alarm_i || warning_i) begin
      state_next = ST_ALARM;
    end else if (!link_up_i) begin
      state_next = ST_WAIT_LINK;
    end else if (!init_done_i) begin
      state_next = ST_INIT;
    end else if (servo_rise) begin
      state_next = ST_READY;
    end else begin
      case (state_reg)
        ST_READY: if (ready_done || !servo_on) state_next = ST_RUN;
        ST_WAIT_LINK, ST_INIT, ST_ALARM: state_next = ST_RUN;
        ST_RUN: state_next = ST_RUN;
        default: state_next = ST_WAIT_LINK;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_WAIT_LINK;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ready_cnt_reg <= 28'h0000000;
    end else if (state_next == ST_READY && state_reg != ST_READY) begin
      ready_cnt_reg <= 28'(READY_CYCLES - 1);
    end else if (!ready_done) begin
      ready_cnt_reg <= ready_cnt_reg - 28'h0000001;
    end
  end

  // Flicker timebase for the second decimal point
  logic [24:0] flick_cnt_reg;
  logic flick_reg;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flick_cnt_reg <= 25'h0000000;
      flick_reg <= 1'b0;
    end else if (flick_cnt_reg == 25'(FLICKER_CYCLES - 1)) begin
      flick_cnt_reg <= 25'h0000000;
      flick_reg <= ~flick_reg;
    end else begin
      flick_cnt_reg <= flick_cnt_reg + 25'h0000001;
    end
  end

  // Suffix digits; stations above 64 are clipped to 64
  logic [6:0] station_clip;
  char_t suffix_hi;
  char_t suffix_lo;
  assign station_clip = (station_no_i > `PTS_STATION_MAX) ? `PTS_STATION_MAX : station_no_i;

  always_comb begin
    if (test_mode_i) begin
      suffix_hi = `PTS_CH_ZERO;
      suffix_lo = `PTS_CH_ZERO;
    end else begin
      suffix_hi = 5'(station_clip / 7'd10);
      suffix_lo = 5'(station_clip % 7'd10);
    end
  end

  char_t ch0_reg;
  char_t ch1_reg;
  char_t ch2_reg;
  logic [2:0] dp_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ch0_reg <= `PTS_CH_BLANK;
      ch1_reg <= `PTS_CH_BLANK;
      ch2_reg <= `PTS_CH_BLANK;
    end else begin
      case (state_reg)
        ST_WAIT_LINK: begin
          ch0_reg <= `PTS_CH_B;
          ch1_reg <= suffix_hi;
          ch2_reg <= suffix_lo;
        end
        ST_INIT: begin
          ch0_reg <= `PTS_CH_C;
          ch1_reg <= suffix_hi;
          ch2_reg <= suffix_lo;
        end
        ST_READY: begin
          ch0_reg <= `PTS_CH_D;
          ch1_reg <= suffix_hi;
          ch2_reg <= suffix_lo;
        end
        ST_ALARM: begin
          ch0_reg <= `PTS_CH_A;
          ch1_reg <= {1'b0, alarm_code_i[7:4]};
          ch2_reg <= {1'b0, alarm_code_i[3:0]};
        end
        ST_WDOG: begin
          ch0_reg <= `PTS_CH_EIGHT;
          ch1_reg <= `PTS_CH_EIGHT;
          ch2_reg <= `PTS_CH_EIGHT;
        end
        default: begin
          ch0_reg <= `PTS_CH_BLANK;
          ch1_reg <= `PTS_CH_BLANK;
          ch2_reg <= `PTS_CH_BLANK;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dp_reg <= 3'h0;
    end else if (state_reg == ST_ALARM && warning_i && !alarm_i && !forced_stop_warning_i && servo_on) begin
      dp_reg <= {1'b0, flick_reg, 1'b0};
    end else begin
      dp_reg <= 3'h0;
    end
  end

  assign disp.ch0 = ch0_reg;
  assign disp.ch1 = ch1_reg;
  assign disp.ch2 = ch2_reg;
  assign disp.dp = dp_reg;

  seg_display u_seg (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .disp(disp),
    .seg0_o(seg0_o),
    .seg1_o(seg1_o),
    .seg2_o(seg2_o)
  );

endmodule // point_table_ctrl

// ==== rtl/pts_cfg.svh ====
// Constants for the point table select and status display block
`ifndef PTS_CFG_SVH
`define PTS_CFG_SVH

`define PTS_CLK_HZ 100000000
`define PTS_TABLE_DEPTH 255
`define PTS_SEL_W 8
`define PTS_POS_W 32
`define PTS_FIELD_W 16
`define PTS_AUX_W 4
`define PTS_SCALED_W 40
`define PTS_STATION_MAX 7'h40

// Display hold times in milliseconds
`define PTS_READY_TIME_MS 2000
`define PTS_FLICKER_TIME_MS 250

// Item codes of a table write
`define PTS_ITEM_POS 3'h0
`define PTS_ITEM_SPEED 3'h1
`define PTS_ITEM_ACCEL 3'h2
`define PTS_ITEM_DECEL 3'h3
`define PTS_ITEM_DWELL 3'h4
`define PTS_ITEM_AUX 3'h5

// Accepted position ranges in table units, checked before scaling
`define PTS_ABS_MIN (-32'sd999999)
`define PTS_ABS_MAX 32'sd9999999
`define PTS_INC_MIN 32'sd0
`define PTS_INC_MAX 32'sd999999

// Display character codes; letters A, b, C, d share the hex codes
`define PTS_CH_A 5'h0a
`define PTS_CH_B 5'h0b
`define PTS_CH_C 5'h0c
`define PTS_CH_D 5'h0d
`define PTS_CH_EIGHT 5'h08
`define PTS_CH_ZERO 5'h00
`define PTS_CH_BLANK 5'h10

`endif

// ==== rtl/pts_pkg.sv ====
// Types shared by the point table select and status display block
package pts_pkg;
  typedef logic [4:0] char_t;
  typedef enum logic [5:0] {
    ST_WAIT_LINK = 6'b000001,
    ST_INIT = 6'b000010,
    ST_READY = 6'b000100,
    ST_RUN = 6'b001000,
    ST_ALARM = 6'b010000,
    ST_WDOG = 6'b100000
  } disp_state_t;
endpackage

// ==== rtl/seg_display.sv ====
// Seven-segment driver for the three-digit status display
`timescale 1ns/1ns
`include "pts_cfg.svh"
module seg_display
  import pts_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  disp_if.snk disp,
  output logic [7:0] seg0_o,
  output logic [7:0] seg1_o,
  output logic [7:0] seg2_o
);

  char_t chars [3];
  logic [7:0] seg_reg [3];

  // Segment order is dp,g,f,e,d,c,b,a
  function automatic logic [6:0] encode(input char_t c);
    case (c)
      5'h00: encode = 7'h3f;
      5'h01: encode = 7'h06;
      5'h02: encode = 7'h5b;
      5'h03: encode = 7'h4f;
      5'h04: encode = 7'h66;
      5'h05: encode = 7'h6d;
      5'h06: encode = 7'h7d;
      5'h07: encode = 7'h07;
      5'h08: encode = 7'h7f;
      5'h09: encode = 7'h6f;
      5'h0a: encode = 7'h77;
      5'h0b: encode = 7'h7c;
      5'h0c: encode = 7'h39;
      5'h0d: encode = 7'h5e;
      5'h0e: encode = 7'h79;
      5'h0f: encode = 7'h71;
      default: encode = 7'h00;
    endcase
  endfunction

  assign chars[0] = disp.ch0;
  assign chars[1] = disp.ch1;
  assign chars[2] = disp.ch2;

  for (genvar i = 0; i < 3; i++) begin : g_digit
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        seg_reg[i] <= 8'h00;
      end else begin
        seg_reg[i] <= {disp.dp[i], encode(chars[i])};
      end
    end
  end

  assign seg0_o = seg_reg[0];
  assign seg1_o = seg_reg[1];
  assign seg2_o = seg_reg[2];

endmodule // seg_display
